/* cpopd_pkg.sv */
// Constants and types shared by the operand and prefix decode block
package cpopd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FEED = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_PAIRS = 8'h0c;
  localparam logic [7:0] OFF_PAIR3 = 8'h10;
  localparam logic [7:0] OFF_STATUS_WORD = 8'h14;
  localparam logic [7:0] OFF_ADDR = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_PC = 8'h20;
  localparam logic [7:0] OFF_BRANCH = 8'h24;
  localparam logic [7:0] OFF_FLAGCTL = 8'h28;
  localparam logic [7:0] OFF_CTRL = 8'h2c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FEED_MODE_LSB = 8;
  localparam int FEED_LOAD_BIT = 12;
  localparam int FEED_WORD_BIT = 13;
  localparam int SEG_LSB = 16;
  localparam int SW_IRQ_EN_BIT = 7;
  localparam int SW_ZERO_BIT = 6;
  localparam int SW_AUX_BIT = 4;
  localparam int SW_CARRY_BIT = 0;
  localparam int FC_ZERO_LSB = 0;
  localparam int FC_AUX_LSB = 4;
  localparam int FC_CARRY_LSB = 8;
  localparam int FC_RES_ZERO_BIT = 16;
  localparam int FC_RES_AUX_BIT = 17;
  localparam int FC_RES_CARRY_BIT = 18;
  localparam int CTRL_RAM_FETCH_BIT = 0;
  localparam int CTRL_SAVE_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values, codes and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_WORD_RESET = 8'h06;
  localparam logic [7:0] PREFIX_CODE = 8'h11;
  localparam logic [7:0] OP_STORE_IMM_ABS = 8'hcf;
  localparam logic [7:0] OP_LOAD_A_PAIR3 = 8'h8b;
  localparam logic [3:0] DATA_WINDOW_SEG = 4'hf;
  localparam logic [9:0] CALL_TABLE_HIGH = 10'h002;
  localparam logic [3:0] CLK_BASE = 4'h1;
  localparam logic [3:0] CLK_BASE_PREFIX = 4'h2;
  localparam logic [3:0] CLK_FLASH = 4'h4;
  localparam logic [3:0] CLK_FLASH_PREFIX = 4'h5;
  localparam logic [5:0] CLK_RAM_FETCH_EXTRA = 6'h06;

  // Addressing mode supplied with each base opcode
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_ABS16 = 3'b001,
    MODE_PAIR3 = 3'b010,
    MODE_PAIR2 = 3'b011,
    MODE_PAIR3_DISP = 3'b100,
    MODE_CALL_TABLE = 3'b101,
    MODE_BRANCH8 = 3'b110,
    MODE_BRANCH16 = 3'b111
  } cpopd_mode_t;

  // Per-flag update operation
  typedef enum logic [2:0] {
    FLAG_KEEP = 3'b000,
    FLAG_CLEAR = 3'b001,
    FLAG_SET = 3'b010,
    FLAG_RESULT = 3'b011,
    FLAG_RESTORE = 3'b100
  } cpopd_flag_op_t;

endpackage

/* cpopd_sync.sv */
// Two flip-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module cpopd_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* cpopd_addr_gen.sv */
// Effective address, branch target and clock count generation
`timescale 1ns/100ps
module cpopd_addr_gen
  import cpopd_pkg::*;
(
  // Decoded instruction
  input wire cpopd_mode_t mode,
  input wire logic prefixed,
  input wire logic is_load,
  input wire logic is_word,
  input wire logic ram_fetch,
  input wire logic [15:0] operand,
  // Register state
  input wire logic [3:0] extension_segment_reg,
  input wire logic [15:0] pointer_pair_two,
  input wire logic [15:0] pointer_pair_three,
  input wire logic [19:0] pc,
  input wire logic [19:0] flash_top,
  // Results
  output logic [19:0] eff_addr,
  output logic [19:0] branch_target,
  output logic [3:0] clocks,
  output logic [5:0] clock_bound,
  output logic flash_hit
);

  // Sign-extend a 16-bit value to 20 bits
  function automatic logic [19:0] sext16(input logic [15:0] v);
    sext16 = {{4{v[15]}}, v};
  endfunction

  logic [15:0] offset16;
  logic [19:0] raw_addr;

  // Low 16 bits of the data address per mode
  always_comb
  begin
    unique case (mode)
      MODE_ABS16: offset16 = operand;
      MODE_PAIR3: offset16 = pointer_pair_three;
      MODE_PAIR2: offset16 = pointer_pair_two;
      MODE_PAIR3_DISP: offset16 = pointer_pair_three + {8'h00, operand[7:0]};
      MODE_CALL_TABLE: offset16 = {CALL_TABLE_HIGH, operand[5:1], 1'b0};
      default: offset16 = 16'h0000;
    endcase
  end

  // Segment part comes from the extension register only when prefixed
  assign raw_addr = prefixed ? {extension_segment_reg, offset16}
                             : {DATA_WINDOW_SEG, offset16};
  assign eff_addr = {raw_addr[19:1], raw_addr[0] & ~is_word};

  // Relative branch targets
  always_comb
  begin
    unique case (mode)
      MODE_BRANCH8: branch_target = pc + sext16({{8{operand[7]}}, operand[7:0]});
      MODE_BRANCH16: branch_target = pc + sext16(operand);
      default: branch_target = pc;
    endcase
  end

  // Clock count depends on the accessed area
  assign flash_hit = is_load && (mode != MODE_NONE) && (eff_addr <= flash_top);
  always_comb
  begin
    if (flash_hit)
      clocks = prefixed ? CLK_FLASH_PREFIX : CLK_FLASH;
    else
      clocks = prefixed ? CLK_BASE_PREFIX : CLK_BASE;
  end

  // Worst case when fetched from RAM: four times plus extra clocks
  assign clock_bound = ram_fetch ? ({clocks, 2'b00} + CLK_RAM_FETCH_EXTRA)
                                 : {2'b00, clocks};

endmodule

/* cpopd_core.sv */
// Operand addressing and prefix decode with APB register access
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
module cpopd_core
  import cpopd_pkg::*;
#(
  parameter logic [19:0] FLASH_TOP = 20'h0ffff
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request pins from interrupt and DMA controllers
  input wire logic irq_req,
  input wire logic dma_req,
  // Acknowledges and decoded address
  output logic irq_ack,
  output logic dma_grant,
  output logic [19:0] data_addr,
  output logic prefix_active
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] accumulator;
  logic [7:0] acc_low;
  logic [15:0] pointer_pair_one;
  logic [15:0] pointer_pair_two;
  logic [15:0] pointer_pair_three;
  logic [3:0] extension_segment_reg;
  logic irq_enable_flag;
  logic zero_flag;
  logic aux_carry_flag;
  logic carry_flag;
  logic [2:0] saved_flags;
  logic [19:0] pc;
  logic [15:0] operand;
  cpopd_mode_t mode;
  logic is_load;
  logic is_word;
  logic prefixed;
  logic ram_fetch;
  logic [19:0] eff_addr;
  logic [19:0] branch_target;
  logic [3:0] clocks;
  logic [5:0] clock_bound;
  logic flash_hit;
  logic [19:0] last_branch;
  logic [3:0] last_clocks;
  logic [5:0] last_bound;
  logic last_flash;
  logic [1:0] req_sync;
  logic access;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] feed_byte;
  logic feed_wr;
  logic is_prefix;
  logic next_prefixed;
  logic next_load;
  logic next_word;
  cpopd_mode_t next_mode;
  logic [31:0] next_rdata;

  // Apply one flag operation
  function automatic logic flag_apply(input logic [2:0] op, input logic cur,
                                      input logic res, input logic saved);
    unique case (op)
      FLAG_CLEAR: flag_apply = 1'b0;
      FLAG_SET: flag_apply = 1'b1;
      FLAG_RESULT: flag_apply = res;
      FLAG_RESTORE: flag_apply = saved;
      default: flag_apply = cur;
    endcase
  endfunction

  // Compare a bus address against a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Answer after one wait state; writes take effect when pready is seen
  assign access = psel & penable;
  assign wr_en = access & pready & pwrite;
  assign rd_en = access & ~pready & ~pwrite;
  assign mapped = hit(paddr, OFF_FEED) | hit(paddr, OFF_OPERAND) | hit(paddr, OFF_ACC) |
                  hit(paddr, OFF_PAIRS) | hit(paddr, OFF_PAIR3) |
                  hit(paddr, OFF_STATUS_WORD) | hit(paddr, OFF_ADDR) |
                  hit(paddr, OFF_STATUS) | hit(paddr, OFF_PC) | hit(paddr, OFF_BRANCH) |
                  hit(paddr, OFF_FLAGCTL) | hit(paddr, OFF_CTRL);

  // Ready and error handshake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Request synchronisers
  // ----------------------------------------------------------------
  cpopd_sync #(
    .WIDTH(2)
  ) u_req_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({dma_req, irq_req}),
    .sync_out(req_sync)
  );

  // Requests are held off while a prefix waits for its instruction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ack <= 1'b0;
      dma_grant <= 1'b0;
    end
    else
    begin
      irq_ack <= req_sync[0] & irq_enable_flag & ~prefix_active;
      dma_grant <= req_sync[1] & ~prefix_active;
    end
  end

  // ----------------------------------------------------------------
  // Prefix and opcode decode
  // ----------------------------------------------------------------
  assign feed_byte = pwdata[7:0];
  assign feed_wr = wr_en & hit(paddr, OFF_FEED);
  assign is_prefix = (feed_byte == PREFIX_CODE) & ~prefix_active;

  // Known base opcodes force their own mode; others take the supplied one
  always_comb
  begin
    next_prefixed = prefix_active;
    next_mode = cpopd_mode_t'(pwdata[FEED_MODE_LSB +: 3]);
    next_load = pwdata[FEED_LOAD_BIT];
    next_word = pwdata[FEED_WORD_BIT];
    if (feed_byte == OP_STORE_IMM_ABS)
    begin
      next_mode = MODE_ABS16;
      next_load = 1'b0;
      next_word = 1'b0;
    end
    else if (feed_byte == OP_LOAD_A_PAIR3)
    begin
      next_mode = MODE_PAIR3;
      next_load = 1'b1;
      next_word = 1'b0;
    end
  end

  // Prefix is pending only until the next byte arrives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prefix_active <= 1'b0;
    else if (feed_wr)
      prefix_active <= is_prefix;
  end

  // Latch decoded instruction attributes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= MODE_NONE;
      prefixed <= 1'b0;
      is_load <= 1'b0;
      is_word <= 1'b0;
    end
    else if (feed_wr && !is_prefix)
    begin
      mode <= next_mode;
      prefixed <= next_prefixed;
      is_load <= next_load;
      is_word <= next_word;
    end
  end

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  cpopd_addr_gen u_addr_gen (
    .mode(mode),
    .prefixed(prefixed),
    .is_load(is_load),
    .is_word(is_word),
    .ram_fetch(ram_fetch),
    .operand(operand),
    .extension_segment_reg(extension_segment_reg),
    .pointer_pair_two(pointer_pair_two),
    .pointer_pair_three(pointer_pair_three),
    .pc(pc),
    .flash_top(FLASH_TOP),
    .eff_addr(eff_addr),
    .branch_target(branch_target),
    .clocks(clocks),
    .clock_bound(clock_bound),
    .flash_hit(flash_hit)
  );

  // Register the decoded results; segment value is taken at this point
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_addr <= 20'h00000;
      last_branch <= 20'h00000;
      last_clocks <= 4'h0;
      last_bound <= 6'h00;
      last_flash <= 1'b0;
    end
    else
    begin
      data_addr <= eff_addr;
      last_branch <= branch_target;
      last_clocks <= clocks;
      last_bound <= clock_bound;
      last_flash <= flash_hit;
    end
  end

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  // Byte accumulator, word pair and three pointer pairs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accumulator <= 8'h00;
      acc_low <= 8'h00;
      pointer_pair_one <= 16'h0000;
      pointer_pair_two <= 16'h0000;
      pointer_pair_three <= 16'h0000;
      extension_segment_reg <= 4'h0;
    end
    else if (wr_en)
    begin
      if (hit(paddr, OFF_ACC))
      begin
        acc_low <= pwdata[7:0];
        accumulator <= pwdata[15:8];
      end
      if (hit(paddr, OFF_PAIRS))
      begin
        pointer_pair_one <= pwdata[15:0];
        pointer_pair_two <= pwdata[31:16];
      end
      if (hit(paddr, OFF_PAIR3))
      begin
        pointer_pair_three <= pwdata[15:0];
        extension_segment_reg <= pwdata[SEG_LSB +: 4];
      end
    end
  end

  // Operand, program counter and control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      operand <= 16'h0000;
      pc <= 20'h00000;
      ram_fetch <= 1'b0;
    end
    else if (wr_en)
    begin
      if (hit(paddr, OFF_OPERAND))
        operand <= pwdata[15:0];
      if (hit(paddr, OFF_PC))
        pc <= pwdata[19:0];
      if (hit(paddr, OFF_CTRL))
        ram_fetch <= pwdata[CTRL_RAM_FETCH_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Status word flags
  // ----------------------------------------------------------------
  // Byte feeds leave flags alone; status word writes load all flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_enable_flag <= STATUS_WORD_RESET[SW_IRQ_EN_BIT];
      zero_flag <= STATUS_WORD_RESET[SW_ZERO_BIT];
      aux_carry_flag <= STATUS_WORD_RESET[SW_AUX_BIT];
      carry_flag <= STATUS_WORD_RESET[SW_CARRY_BIT];
    end
    else if (wr_en && hit(paddr, OFF_STATUS_WORD))
    begin
      irq_enable_flag <= pwdata[SW_IRQ_EN_BIT];
      zero_flag <= pwdata[SW_ZERO_BIT];
      aux_carry_flag <= pwdata[SW_AUX_BIT];
      carry_flag <= pwdata[SW_CARRY_BIT];
    end
    else if (wr_en && hit(paddr, OFF_FLAGCTL))
    begin
      zero_flag <= flag_apply(pwdata[FC_ZERO_LSB +: 3], zero_flag,
                              pwdata[FC_RES_ZERO_BIT], saved_flags[2]);
      aux_carry_flag <= flag_apply(pwdata[FC_AUX_LSB +: 3], aux_carry_flag,
                                   pwdata[FC_RES_AUX_BIT], saved_flags[1]);
      carry_flag <= flag_apply(pwdata[FC_CARRY_LSB +: 3], carry_flag,
                               pwdata[FC_RES_CARRY_BIT], saved_flags[0]);
    end
  end

  // Saved flag copy for later restore
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      saved_flags <= 3'b000;
    else if (wr_en && hit(paddr, OFF_CTRL) && pwdata[CTRL_SAVE_BIT])
      saved_flags <= {zero_flag, aux_carry_flag, carry_flag};
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (paddr)
      OFF_FEED: next_rdata = {18'h00000, is_word, is_load, 1'b0, mode, 8'h00};
      OFF_OPERAND: next_rdata = {16'h0000, operand};
      OFF_ACC: next_rdata = {16'h0000, accumulator, acc_low};
      OFF_PAIRS: next_rdata = {pointer_pair_two, pointer_pair_one};
      OFF_PAIR3: next_rdata = {12'h000, extension_segment_reg, pointer_pair_three};
      OFF_STATUS_WORD: next_rdata = {24'h000000, irq_enable_flag, zero_flag, 1'b0,
                                     aux_carry_flag, 3'b000, carry_flag};
      OFF_ADDR: next_rdata = {12'h000, data_addr};
      OFF_STATUS: next_rdata = {18'h00000, last_bound, last_flash, prefixed,
                                prefix_active, 1'b0, last_clocks};
      OFF_PC: next_rdata = {12'h000, pc};
      OFF_BRANCH: next_rdata = {12'h000, last_branch};
      OFF_CTRL: next_rdata = {29'h00000000, saved_flags[0], 1'b0, ram_fetch};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data is captured in the wait cycle and held for the answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
      prdata <= next_rdata;
  end

endmodule

/* cpopd_core_chk.sv */
// Port-level assertions for the operand and prefix decode block
`timescale 1ns/100ps
module cpopd_core_chk
  import cpopd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Pins and decode
  input wire logic irq_req,
  input wire logic dma_req,
  input wire logic irq_ack,
  input wire logic dma_grant,
  input wire logic [19:0] data_addr,
  input wire logic prefix_active
);
  // ----------------------------------------------------------------
  // Completed feed writes
  // ----------------------------------------------------------------
  logic wr_feed;
  assign wr_feed = psel && penable && pready && pwrite && (paddr == OFF_FEED);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_prefix_set: assert property (
    wr_feed && pwdata[7:0] == PREFIX_CODE && !prefix_active |=> prefix_active)
    else $error("prefix byte did not arm");
  a_prefix_once: assert property (
    wr_feed && prefix_active |=> !prefix_active)
    else $error("prefix outlived next byte");
  a_prefix_hold: assert property (
    prefix_active && !wr_feed |=> prefix_active)
    else $error("prefix dropped early");
  a_irq_blocked: assert property (
    prefix_active && $past(prefix_active) |-> !irq_ack)
    else $error("interrupt taken after prefix");
  a_dma_blocked: assert property (
    prefix_active && $past(prefix_active) |-> !dma_grant)
    else $error("dma granted after prefix");
  a_dma_latency: assert property (
    dma_grant == ($past(dma_req, 3) && !$past(prefix_active)))
    else $error("dma grant timing wrong");
  a_irq_cause: assert property (
    irq_ack |-> $past(irq_req, 3) && !$past(prefix_active))
    else $error("interrupt ack without request");
  a_window_seg: assert property (
    wr_feed && !prefix_active && pwdata[10:8] == 3'h1 && pwdata[7:0] != PREFIX_CODE
    && pwdata[7:0] != OP_LOAD_A_PAIR3 |-> ##2 data_addr[19:16] == DATA_WINDOW_SEG)
    else $error("plain access left data window");
endmodule

/* cpopd_req_model.sv */
// Interrupt and DMA requester standing on the far side of the pins
`timescale 1ns/100ps
module cpopd_req_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands and answers
  input wire logic irq_go,
  input wire logic dma_go,
  input wire logic irq_ack,
  input wire logic dma_grant,
  // Request levels
  output logic irq_req,
  output logic dma_req
);
  // Raise on command, hold until answered
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_req <= 1'b0;
      dma_req <= 1'b0;
    end
    else
    begin
      irq_req <= irq_go | (irq_req & ~irq_ack);
      dma_req <= dma_go | (dma_req & ~dma_grant);
    end
endmodule

/* cpopd_core_bench.sv */
// Self-checking bench for the operand and prefix decode block
`timescale 1ns/100ps
module cpopd_core_bench
  import cpopd_pkg::*;
;
  typedef struct {logic [31:0] m; logic [31:0] e; logic r;} cpopd_note_t;
  logic pclk, presetn, psel, penable, pwrite, irq_go, dma_go;
  logic pready, pslverr, irq_req, dma_req, irq_ack, dma_grant, prefix_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [19:0] data_addr;
  logic [5:0] c, b;
  int error_cnt, checked, cyc, k;
  cpopd_note_t q[$];
  cpopd_note_t n;

  cpopd_core i_cpopd_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req(irq_req), .dma_req(dma_req), .irq_ack(irq_ack),
    .dma_grant(dma_grant), .data_addr(data_addr), .prefix_active(prefix_active));
  cpopd_req_model i_cpopd_req_model (.pclk(pclk), .presetn(presetn), .irq_go(irq_go),
    .dma_go(dma_go), .irq_ack(irq_ack), .dma_grant(dma_grant), .irq_req(irq_req),
    .dma_req(dma_req));

  always #5 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task finish_test;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One APB transfer, waiting for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic r = 0);
    q.push_back('{m, e, r});
    apb(1'b0, a, 32'h0);
  endtask

  task feed(input logic [7:0] bt, input logic [2:0] md, input logic ld, input logic wd);
    apb(1'b1, OFF_FEED, {18'h0, wd, ld, 1'b0, md, bt});
  endtask

  task go(input logic d);
    if (d)
      dma_go <= 1'b1;
    else
      irq_go <= 1'b1;
    @(posedge pclk);
    irq_go <= 1'b0;
    dma_go <= 1'b0;
  endtask

  // Bounded wait for an acknowledge or grant
  task wait_hi(input logic d);
    k = 0;
    while ((d ? dma_grant : irq_ack) !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    check(d ? "dma_grant" : "irq_ack", {32'h0, d ? dma_grant : irq_ack}, 33'h1);
  endtask

  // Read monitor compares against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
    begin
      n = q.pop_front();
      check("read", {pslverr, prdata & n.m}, {n.r, n.e});
    end

  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    irq_go = 0; dma_go = 0; seed = 32'h25f4;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_STATUS_WORD, 32'hd1, {24'h0, STATUS_WORD_RESET & 8'hd1});
    rd(OFF_ADDR, 32'hfffff, 32'hf0000);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      apb(1'b1, OFF_ACC, seed);
      rd(OFF_ACC, 32'hffff, seed & 32'hffff);
      apb(1'b1, OFF_PAIRS, ~seed);
      rd(OFF_PAIRS, 32'hffffffff, ~seed);
      apb(1'b1, OFF_PAIR3, seed);
      rd(OFF_PAIR3, 32'hfffff, seed & 32'hfffff);
    end
    apb(1'b1, OFF_PAIR3, 32'h3abcd);
    apb(1'b1, OFF_OPERAND, 32'h5678);
    feed(PREFIX_CODE, 3'h0, 1'b0, 1'b0);
    rd(OFF_STATUS, 32'h20, 32'h20);
    feed(OP_STORE_IMM_ABS, 3'h1, 1'b0, 1'b0);
    rd(OFF_ADDR, 32'hfffff, 32'h35678);
    rd(OFF_STATUS, 32'h3f6f, 32'h0242);
    feed(OP_STORE_IMM_ABS, 3'h1, 1'b0, 1'b0);
    rd(OFF_ADDR, 32'hfffff, 32'hf5678);
    rd(OFF_STATUS, 32'h3f6f, 32'h0101);
    apb(1'b1, OFF_OPERAND, 32'h1235);
    feed(8'h00, 3'h1, 1'b0, 1'b1);
    rd(OFF_ADDR, 32'hfffff, 32'hf1234);
    apb(1'b1, OFF_OPERAND, 32'h003f);
    feed(8'h00, 3'h5, 1'b0, 1'b0);
    rd(OFF_ADDR, 32'hffff, 32'h00be);
    apb(1'b1, OFF_PAIR3, 32'h01234);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFF_CTRL, {31'h0, i[1]});
      if (i[0])
        feed(PREFIX_CODE, 3'h0, 1'b0, 1'b0);
      feed(OP_LOAD_A_PAIR3, 3'h2, 1'b1, 1'b0);
      c = i[0] ? 6'd5 : 6'd1;
      b = i[1] ? 6'd4 * c + 6'd6 : c;
      rd(OFF_STATUS, 32'h3f8f, {18'h0, b, i[0], 3'h0, c[3:0]});
    end
    apb(1'b1, OFF_PC, 32'h10020);
    apb(1'b1, OFF_OPERAND, 32'h00f0);
    feed(8'h00, 3'h6, 1'b0, 1'b0);
    rd(OFF_BRANCH, 32'hfffff, 32'h10010);
    apb(1'b1, OFF_OPERAND, 32'h8000);
    feed(8'h00, 3'h7, 1'b0, 1'b0);
    rd(OFF_BRANCH, 32'hfffff, 32'h08020);
    apb(1'b1, OFF_STATUS_WORD, 32'hd1);
    rd(OFF_STATUS_WORD, 32'hd1, 32'hd1);
    apb(1'b1, OFF_CTRL, 32'h2);
    apb(1'b1, OFF_FLAGCTL, 32'h110);
    rd(OFF_STATUS_WORD, 32'hd1, 32'hc0);
    apb(1'b1, OFF_FLAGCTL, 32'h423);
    rd(OFF_STATUS_WORD, 32'hd1, 32'h91);
    rd(OFF_CTRL, 32'h4, 32'h4);
    feed(OP_LOAD_A_PAIR3, 3'h2, 1'b1, 1'b0);
    rd(OFF_STATUS_WORD, 32'hd1, 32'h91);
    apb(1'b1, 8'h30, 32'hffffffff);
    rd(8'h30, 32'hffffffff, 32'h0, 1'b1);
    go(1'b0);
    wait_hi(1'b0);
    apb(1'b1, OFF_STATUS_WORD, 32'h0);
    go(1'b0);
    repeat (10) @(posedge pclk);
    check("irq_ack", {32'h0, irq_ack}, 33'h0);
    apb(1'b1, OFF_STATUS_WORD, 32'h80);
    wait_hi(1'b0);
    feed(PREFIX_CODE, 3'h0, 1'b0, 1'b0);
    go(1'b1);
    repeat (8) @(posedge pclk);
    check("dma_grant", {32'h0, dma_grant}, 33'h0);
    feed(8'h00, 3'h0, 1'b0, 1'b0);
    wait_hi(1'b1);
    finish_test();
  end
endmodule

bind cpopd_core cpopd_core_chk i_cpopd_core_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .irq_req(irq_req), .dma_req(dma_req), .irq_ack(irq_ack), .dma_grant(dma_grant),
  .data_addr(data_addr), .prefix_active(prefix_active));
